/* logic/ldcb_defines.svh */
/*
  Constants of the logical device configuration bank: port keys, global
  indices, per-function indices, function numbers and reset values.
  Assumes it is included by bare name from the package and the bank.
*/
`ifndef LDCB_DEFINES_SVH
`define LDCB_DEFINES_SVH

// ---------------------------------------------------------------
// configuration port keys
// ---------------------------------------------------------------
`define LDCB_KEY_ENTER 8'h55
`define LDCB_KEY_EXIT 8'hAA

// ---------------------------------------------------------------
// global indices and fields
// ---------------------------------------------------------------
`define LDCB_IDX_CTRL 8'h02
`define LDCB_IDX_LDN 8'h07
`define LDCB_IDX_PWR 8'h22
`define LDCB_SOFT_BIT 0
`define LDCB_PWR_SB_MASK 8'hA0
`define LDCB_RV_ZERO 8'h00

// ---------------------------------------------------------------
// per-function indices
// ---------------------------------------------------------------
`define LDCB_IDX_ACT 8'h30
`define LDCB_IDX_BHI 8'h60
`define LDCB_IDX_BLO 8'h61
`define LDCB_IDX_IRQ 8'h70
`define LDCB_IDX_IRQ2 8'h72
`define LDCB_IDX_DMA 8'h74
`define LDCB_IDX_MODE 8'hF0
`define LDCB_IDX_OPT 8'hF1
`define LDCB_IDX_TYPE 8'hF2
`define LDCB_IDX_DRV0 8'hF4
`define LDCB_IDX_DRV1 8'hF5

// ---------------------------------------------------------------
// function numbers
// ---------------------------------------------------------------
`define LDCB_LD_FLOPPY 4'h0
`define LDCB_LD_PAR 4'h3
`define LDCB_LD_SER1 4'h4
`define LDCB_LD_SER2 4'h5
`define LDCB_LD_KBD 4'h7
`define LDCB_LD_GAME 4'h9
`define LDCB_LD_WAKE 4'hA
`define LDCB_LD_MIDI 4'hB

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LDCB_RV_FLOPPY_BHI 8'h03
`define LDCB_RV_FLOPPY_BLO 8'hF0
`define LDCB_RV_FLOPPY_IRQ 8'h06
`define LDCB_RV_FLOPPY_DMA 8'h02
`define LDCB_RV_FLOPPY_MODE 8'h0E
`define LDCB_RV_FLOPPY_TYPE 8'hFF
`define LDCB_RV_PAR_DMA 8'h04
`define LDCB_RV_PAR_MODE 8'h3C
`define LDCB_RV_INFRARED_OPT 8'h02
`define LDCB_RV_INFRARED_TMO 8'h03
`define LDCB_RV_MIDI_BHI 8'h03
`define LDCB_RV_MIDI_BLO 8'h30
`define LDCB_RV_MIDI_IRQ 8'h05
`define LDCB_NUM_ENT 44

`endif

/* logic/ldcb_pkg.sv */
/*
  Types of the logical device configuration bank.
  Assumes the defines header is on the include path.
*/
`include "ldcb_defines.svh"

package ldcb_pkg;

  // which reset sources load a register
  typedef enum logic [1:0] {
    LDCB_CLS_ALL = 2'h0, // hard, main, standby and soft
    LDCB_CLS_HW = 2'h1,  // hard, main and standby only
    LDCB_CLS_SB = 2'h3   // standby power-on only
  } ldcb_cls_e;

  // run or configuration state
  typedef enum logic {
    LDCB_ST_RUN = 1'b0,
    LDCB_ST_CFG = 1'b1
  } ldcb_state_e;

  // one implemented per-function register
  typedef struct packed {
    logic [3:0] ldn;
    logic [7:0] idx;
    logic [7:0] rv;
    ldcb_cls_e cls;
  } ldcb_ent_s;

  // one host port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic data_sel;
    logic [7:0] wdata;
  } ldcb_io_s;

endpackage

/* logic/ldcb_bank.sv */
/*
  Per-function configuration register bank behind the index/data
  configuration ports, with its four reset sources.
  Assumes the host port decoder presents one-cycle accesses on clk_i,
  config/index port when data_sel is 0 and data port when it is 1.
*/
`include "ldcb_defines.svh"

module ldcb_bank (
  input wire logic clk_i,                // 100 MHz clock
  input wire logic rst_i,                // standby supply power-on reset
  input wire logic bus_reset_pin_n_i,    // bus reset pin, async, low
  input wire logic main_por_i,           // main supply power-on, async
  input wire ldcb_pkg::ldcb_io_s io_i,   // host port access
  output logic [7:0] rd_data_o,          // read data, registered
  output logic rd_valid_o,               // read data valid pulse
  output logic cfg_mode_o,               // in configuration state
  output logic soft_reset_o,             // soft reset pulse
  output logic [7:0] power_ctl_o         // global power control
);
  import ldcb_pkg::*;

  localparam int NE = `LDCB_NUM_ENT;
  localparam logic [5:0] NONE = 6'h3F;

  // ---------------------------------------------------------------
  // register table
  // ---------------------------------------------------------------

  // each entry names its function, its index, the value it loads on
  // reset and the class of reset sources that load it; the table is
  // walked by constant functions only, so it costs no logic of its own
  // beyond the comparators of the lookup
  // build one table entry
  function automatic ldcb_ent_s mk(input logic [3:0] l,
                                   input logic [7:0] i,
                                   input logic [7:0] v,
                                   input ldcb_cls_e c);
    ldcb_ent_s t;
    t.ldn = l;
    t.idx = i;
    t.rv = v;
    t.cls = c;
    return t;
  endfunction

  // implemented registers with their reset value and class
  function automatic ldcb_ent_s ent(input int e);
    ldcb_ent_s t;
    t = mk(4'hF, 8'h00, `LDCB_RV_ZERO, LDCB_CLS_ALL);
    case (e)
      // floppy function
      0: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      1: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_BHI,
          `LDCB_RV_FLOPPY_BHI, LDCB_CLS_ALL);
      2: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_BLO,
          `LDCB_RV_FLOPPY_BLO, LDCB_CLS_ALL);
      3: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_IRQ,
          `LDCB_RV_FLOPPY_IRQ, LDCB_CLS_ALL);
      4: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_DMA,
          `LDCB_RV_FLOPPY_DMA, LDCB_CLS_ALL);
      5: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_MODE,
          `LDCB_RV_FLOPPY_MODE, LDCB_CLS_HW);
      6: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_OPT,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      7: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_TYPE,
          `LDCB_RV_FLOPPY_TYPE, LDCB_CLS_HW);
      8: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_DRV0,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      9: t = mk(`LDCB_LD_FLOPPY, `LDCB_IDX_DRV1,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      // parallel function
      10: t = mk(`LDCB_LD_PAR, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      11: t = mk(`LDCB_LD_PAR, `LDCB_IDX_BHI,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      12: t = mk(`LDCB_LD_PAR, `LDCB_IDX_BLO,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      13: t = mk(`LDCB_LD_PAR, `LDCB_IDX_IRQ,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      14: t = mk(`LDCB_LD_PAR, `LDCB_IDX_DMA,
          `LDCB_RV_PAR_DMA, LDCB_CLS_ALL);
      15: t = mk(`LDCB_LD_PAR, `LDCB_IDX_MODE,
          `LDCB_RV_PAR_MODE, LDCB_CLS_HW);
      16: t = mk(`LDCB_LD_PAR, `LDCB_IDX_OPT,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      // first serial function
      17: t = mk(`LDCB_LD_SER1, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      18: t = mk(`LDCB_LD_SER1, `LDCB_IDX_BHI,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      19: t = mk(`LDCB_LD_SER1, `LDCB_IDX_BLO,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      20: t = mk(`LDCB_LD_SER1, `LDCB_IDX_IRQ,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      21: t = mk(`LDCB_LD_SER1, `LDCB_IDX_MODE,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      // second serial function, 0x62/0x63/0x74 left out on purpose
      22: t = mk(`LDCB_LD_SER2, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_SB);
      23: t = mk(`LDCB_LD_SER2, `LDCB_IDX_BHI,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      24: t = mk(`LDCB_LD_SER2, `LDCB_IDX_BLO,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      25: t = mk(`LDCB_LD_SER2, `LDCB_IDX_IRQ,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      26: t = mk(`LDCB_LD_SER2, `LDCB_IDX_MODE,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      27: t = mk(`LDCB_LD_SER2, `LDCB_IDX_OPT,
          `LDCB_RV_INFRARED_OPT, LDCB_CLS_HW);
      28: t = mk(`LDCB_LD_SER2, `LDCB_IDX_TYPE,
          `LDCB_RV_INFRARED_TMO, LDCB_CLS_HW);
      // keyboard function
      29: t = mk(`LDCB_LD_KBD, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      30: t = mk(`LDCB_LD_KBD, `LDCB_IDX_IRQ,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      31: t = mk(`LDCB_LD_KBD, `LDCB_IDX_IRQ2,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      32: t = mk(`LDCB_LD_KBD, `LDCB_IDX_MODE,
          `LDCB_RV_ZERO, LDCB_CLS_HW);
      // game function
      33: t = mk(`LDCB_LD_GAME, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      34: t = mk(`LDCB_LD_GAME, `LDCB_IDX_BHI,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      35: t = mk(`LDCB_LD_GAME, `LDCB_IDX_BLO,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      // wake-event function, 0xF1 left out on purpose
      36: t = mk(`LDCB_LD_WAKE, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      37: t = mk(`LDCB_LD_WAKE, `LDCB_IDX_BHI,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      38: t = mk(`LDCB_LD_WAKE, `LDCB_IDX_BLO,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      39: t = mk(`LDCB_LD_WAKE, `LDCB_IDX_MODE,
          `LDCB_RV_ZERO, LDCB_CLS_SB);
      // midi function
      40: t = mk(`LDCB_LD_MIDI, `LDCB_IDX_ACT,
          `LDCB_RV_ZERO, LDCB_CLS_ALL);
      41: t = mk(`LDCB_LD_MIDI, `LDCB_IDX_BHI,
          `LDCB_RV_MIDI_BHI, LDCB_CLS_ALL);
      42: t = mk(`LDCB_LD_MIDI, `LDCB_IDX_BLO,
          `LDCB_RV_MIDI_BLO, LDCB_CLS_HW);
      43: t = mk(`LDCB_LD_MIDI, `LDCB_IDX_IRQ,
          `LDCB_RV_MIDI_IRQ, LDCB_CLS_ALL);
      default: t = mk(4'hF, 8'h00, `LDCB_RV_ZERO, LDCB_CLS_ALL);
    endcase
    return t;
  endfunction

  // find the entry for a function and index, NONE if unimplemented
  // indices are unique within a function, so at most one entry can
  // match and the order of the walk does not matter
  function automatic logic [5:0] lookup(input logic [7:0] l,
                                        input logic [7:0] i);
    logic [5:0] hit;
    ldcb_ent_s t;
    hit = NONE;
    for (int e = 0; e < NE; e++) begin
      t = ent(e);
      if ({4'h0, t.ldn} == l && t.idx == i) begin
        hit = 6'(e);
      end
    end
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  logic [1:0] hard_sync_r;
  logic [1:0] main_sync_r;
  logic soft_r;
  logic rst_hw;
  logic rst_all;

  // the pin resets arrive with no relation to clk_i; they are seen only
  // through the synchronisers, so a pin pulse shorter than one clock
  // may be missed, and a reset takes effect three edges after the pin
  // soft reset reaches only the all-source class, the selector and the power control bits other than 5 and 7
  // two-stage synchronisers for the asynchronous reset pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hard_sync_r <= 2'h0;
      main_sync_r <= 2'h0;
    end else begin
      hard_sync_r <= {hard_sync_r[0], ~bus_reset_pin_n_i};
      main_sync_r <= {main_sync_r[0], main_por_i};
    end
  end

  // hard or power-on, and any reset including soft
  assign rst_hw = rst_i | hard_sync_r[1] | main_sync_r[1];
  assign rst_all = rst_hw | soft_r;

  // ---------------------------------------------------------------
  // host port decode
  // ---------------------------------------------------------------
  ldcb_state_e state_r;
  logic [7:0] index_r;
  logic [7:0] ldn_r;
  logic [7:0] pwr_r;
  logic [7:0] regs_r [NE];
  logic [5:0] hit;
  logic cfg;
  logic idx_wr;
  logic dat_wr;

  // the port strobes come from logic on clk_i and need no synchroniser;
  // each strobe stands for exactly one edge
  // accesses qualified by the configuration state
  assign cfg = (state_r == LDCB_ST_CFG);
  assign idx_wr = io_i.wr & ~io_i.data_sel & cfg;
  assign dat_wr = io_i.wr & io_i.data_sel & cfg;
  assign hit = lookup(ldn_r, index_r);

  // run/config state from keys on the config port
  // keys are taken only on the config port; a data port write can
  // never open or close the configuration state
  always_ff @(posedge clk_i) begin
    if (rst_hw) begin
      state_r <= LDCB_ST_RUN;
    end else if (io_i.wr && !io_i.data_sel) begin
      case (state_r)
        LDCB_ST_RUN: begin
          if (io_i.wdata == `LDCB_KEY_ENTER) begin
            state_r <= LDCB_ST_CFG;
          end
        end
        LDCB_ST_CFG: begin
          if (io_i.wdata == `LDCB_KEY_EXIT) begin
            state_r <= LDCB_ST_RUN;
          end
        end
        default: state_r <= LDCB_ST_RUN;
      endcase
    end
  end

  // index port; the exit key is not taken as an index
  always_ff @(posedge clk_i) begin
    if (rst_hw) begin
      index_r <= 8'h00;
    end else if (idx_wr && io_i.wdata != `LDCB_KEY_EXIT) begin
      index_r <= io_i.wdata;
    end
  end

  // function number selector, cleared by soft reset too
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      ldn_r <= 8'h00;
    end else if (dat_wr && index_r == `LDCB_IDX_LDN) begin
      ldn_r <= io_i.wdata;
    end
  end

  // soft reset pulse from the control register, self clearing
  always_ff @(posedge clk_i) begin
    if (rst_hw) begin
      soft_r <= 1'b0;
    end else begin
      soft_r <= dat_wr && index_r == `LDCB_IDX_CTRL &&
                io_i.wdata[`LDCB_SOFT_BIT];
    end
  end

  // power control: bits 5 and 7 survive all but standby power-on
  // those bits hold state that must outlive the main supply, so every
  // other reset source clears only the remaining bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r <= 8'h00;
    end else if (rst_hw || soft_r) begin
      pwr_r <= pwr_r & `LDCB_PWR_SB_MASK;
    end else if (dat_wr && index_r == `LDCB_IDX_PWR) begin
      pwr_r <= io_i.wdata;
    end
  end

  // ---------------------------------------------------------------
  // per-function registers
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NE; g++) begin : g_reg
    localparam ldcb_ent_s T = ent(g);
    logic rst_e;

    // pick the reset sources of this register's class
    // a standby-only register keeps its contents through every reset
    // but rst_i, so its setting survives a main supply cycle
    always_comb begin
      case (T.cls)
        LDCB_CLS_ALL: rst_e = rst_all;
        LDCB_CLS_HW: rst_e = rst_hw;
        LDCB_CLS_SB: rst_e = rst_i;
        default: rst_e = rst_all;
      endcase
    end

    // storage, written only through the selected function's bank
    always_ff @(posedge clk_i) begin
      if (rst_e) begin
        regs_r[g] <= T.rv;
      end else if (dat_wr && hit == 6'(g)) begin
        regs_r[g] <= io_i.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rd_nxt;

  // the selector and power control are answered here, not by the
  // table, because they live outside every function's bank; a read
  // of the index port in configuration state returns the current index
  // reserved and unimplemented indices read zero
  always_comb begin
    rd_nxt = 8'h00;
    if (cfg && !io_i.data_sel) begin
      rd_nxt = index_r;
    end else if (cfg) begin
      if (index_r == `LDCB_IDX_LDN) begin
        rd_nxt = ldn_r;
      end else if (index_r == `LDCB_IDX_PWR) begin
        rd_nxt = pwr_r;
      end else if (hit != NONE) begin
        rd_nxt = regs_r[hit];
      end
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_hw) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= io_i.rd;
      if (io_i.rd) begin
        rd_data_o <= rd_nxt;
      end
    end
  end

  // status outputs
  // cfg_mode_o follows the state register directly, so it drops on
  // the same edge that takes the exit key
  assign cfg_mode_o = cfg;
  assign soft_reset_o = soft_r;
  assign power_ctl_o = pwr_r;

endmodule

/* tb/ldcb_host.sv */
/*
  Host model for the configuration ports: one-cycle index and data
  port strobes, and read answers picked up one cycle after the strobe.
  Assumes the bank takes a strobe on the rising edge of clk_i.
*/
module ldcb_host (
  input wire logic clk_i,            // bench clock
  input wire logic [7:0] rd_data_i,  // read data from the bank
  input wire logic rd_valid_i,       // read answer pulse
  output ldcb_pkg::ldcb_io_s io_o    // port access to the bank
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldcb_pkg::*;

  // ------------------------------------------------------------
  // port cycles
  // ------------------------------------------------------------
  // bus is idle until the first task call
  initial io_o = '{1'b0, 1'b0, 1'b0, 8'h00};

  // write strobe for one cycle; released data shows inverted bits
  task put(input logic sel, input logic [7:0] d);
    @(posedge clk_i);
    io_o <= '{1'b1, 1'b0, sel, d};
    @(posedge clk_i);
    io_o <= '{1'b0, 1'b0, 1'b0, ~d};
  endtask

  // read strobe, then sample the answer on the following edge
  task get(input logic sel, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    io_o <= '{1'b0, 1'b1, sel, 8'h00};
    @(posedge clk_i);
    io_o <= '{1'b0, 1'b0, 1'b0, 8'hFF};
    @(posedge clk_i);
    d = rd_data_i;
    v = rd_valid_i;
  endtask

  // select a function, then point the index at one of its registers
  task pick(input logic [3:0] ldn, input logic [7:0] idx);
    put(1'b0, 8'h07);
    put(1'b1, {4'h0, ldn});
    put(1'b0, idx);
  endtask
endmodule

/* tb/ldcb_bank_monitor.sv */
/*
  Checker for the configuration bank port timing and reset behaviour.
  Assumes it is bound to the bank and sees only its ports.
*/
module ldcb_bank_monitor (
  input wire logic clk_i,               // clock
  input wire logic rst_i,               // standby power-on reset
  input wire logic bus_reset_pin_n_i,   // hard reset pin, low
  input wire logic main_por_i,          // main power-on reset
  input wire ldcb_pkg::ldcb_io_s io_i,  // host port access
  input wire logic [7:0] rd_data_o,     // read data
  input wire logic rd_valid_o,          // read answer pulse
  input wire logic cfg_mode_o,          // configuration state
  input wire logic soft_reset_o,        // soft reset pulse
  input wire logic [7:0] power_ctl_o    // global power control
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldcb_pkg::*;
  logic [7:0] idx_r;

  // follow index port writes made in configuration state
  always_ff @(posedge clk_i) begin
    if (rst_i || !bus_reset_pin_n_i || main_por_i) begin
      idx_r <= 8'h00;
    end else if (cfg_mode_o && io_i.wr && !io_i.data_sel &&
                 io_i.wdata != 8'hAA) begin
      idx_r <= io_i.wdata;
    end
  end

  // ------------------------------------------------------------
  // sequences and assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !bus_reset_pin_n_i || main_por_i);

  // write of a key or index to the config port
  sequence s_cfg_write(logic [7:0] d);
    io_i.wr && !io_i.data_sel && io_i.wdata == d;
  endsequence

  // data port write of bit 0 to the control index
  sequence s_soft_req;
    cfg_mode_o && io_i.wr && io_i.data_sel && idx_r == 8'h02 &&
      io_i.wdata[0];
  endsequence

  chk_read_answer: assert property (io_i.rd |=> rd_valid_o)
    else $error("read not answered on the next cycle");
  chk_valid_cause: assert property (rd_valid_o |-> $past(io_i.rd))
    else $error("read valid without a read strobe");
  chk_run_reads_zero: assert property
    (!cfg_mode_o && io_i.rd |=> rd_data_o == 8'h00)
    else $error("read outside configuration state not zero");
  chk_enter_key: assert property (s_cfg_write(8'h55) |=> cfg_mode_o)
    else $error("enter key did not open configuration state");
  chk_exit_key: assert property
    (cfg_mode_o ##0 s_cfg_write(8'hAA) |=> !cfg_mode_o)
    else $error("exit key did not close configuration state");
  chk_soft_pulse: assert property
    (s_soft_req |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse missing or too long");
  chk_standby_bits: assert property
    (soft_reset_o |-> ##2
      ((power_ctl_o ^ $past(power_ctl_o, 2)) & 8'hA0) == 8'h00)
    else $error("soft reset disturbed standby power bits");
  chk_power_clear: assert property
    (soft_reset_o |-> ##2 (power_ctl_o & 8'h5F) == 8'h00)
    else $error("soft reset left power control bits set");
  chk_data_holds: assert property
    (!io_i.rd && !io_i.wr && !soft_reset_o |=> $stable(rd_data_o))
    else $error("read data changed without a read");
endmodule

bind ldcb_bank ldcb_bank_monitor ldcb_bank_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .bus_reset_pin_n_i(bus_reset_pin_n_i),
  .main_por_i(main_por_i), .io_i(io_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .cfg_mode_o(cfg_mode_o),
  .soft_reset_o(soft_reset_o), .power_ctl_o(power_ctl_o)
);

/* tb/ldcb_bank_test.sv */
/*
  Testbench for the configuration bank: reset values, the four reset
  sources over random contents, run-state refusal and reserved places.
  Assumes the host model and the bound checker are compiled alongside.
*/
module ldcb_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ldcb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_reset_pin_n_i = 1'b1;
  logic main_por_i = 1'b0;
  ldcb_io_s io_i;
  logic [7:0] rd_data_o;
  logic [7:0] power_ctl_o;
  logic rd_valid_o;
  logic cfg_mode_o;
  logic soft_reset_o;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h1D89FC91;
  logic [7:0] d;
  logic v;
  logic [7:0] pv;
  logic [7:0] wv [44];
  // function, index, reset value, reset class (0 all, 1 no soft, 3 standby)
  logic [23:0] tbl [44] = '{
    24'h030000, 24'h060030, 24'h061F00, 24'h070060, 24'h074020,
    24'h0F00E1, 24'h0F1001, 24'h0F2FF1, 24'h0F4001, 24'h0F5001,
    24'h330000, 24'h360000, 24'h361000, 24'h370000, 24'h374040,
    24'h3F03C1, 24'h3F1001, 24'h430000, 24'h460000, 24'h461000,
    24'h470000, 24'h4F0001, 24'h530003, 24'h560000, 24'h561000,
    24'h570000, 24'h5F0001, 24'h5F1021, 24'h5F2031, 24'h730000,
    24'h770000, 24'h772000, 24'h7F0001, 24'h930000, 24'h960000,
    24'h961000, 24'hA30000, 24'hA60000, 24'hA61000, 24'hAF0003,
    24'hB30000, 24'hB60030, 24'hB61301, 24'hB70050};
  // reserved and unimplemented places: function and index
  logic [11:0] rsv [7] = '{12'h562, 12'h563, 12'h574, 12'hAF1,
    12'h130, 12'h760, 12'h0F3};

  always #5 clk_i = ~clk_i;

  ldcb_bank ldcb_bank_inst (
    .clk_i(clk_i), .rst_i(rst_i), .bus_reset_pin_n_i(bus_reset_pin_n_i),
    .main_por_i(main_por_i), .io_i(io_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .cfg_mode_o(cfg_mode_o),
    .soft_reset_o(soft_reset_o), .power_ctl_o(power_ctl_o));
  ldcb_host ldcb_host_inst (.clk_i(clk_i), .rd_data_i(rd_data_o),
    .rd_valid_i(rd_valid_o), .io_o(io_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task wrap_up;
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task wr(input logic sel, input logic [7:0] dd);
    ldcb_host_inst.put(sel, dd);
  endtask

  // read a port and compare both the answer pulse and the data
  task rd(input logic sel, input logic [7:0] want);
    ldcb_host_inst.get(sel, d, v);
    check({7'h00, v}, 8'h01);
    check(d, want);
  endtask

  // value after reset source k: 0 standby, 1 hard, 2 main, 3 soft
  function automatic logic [7:0] exp_val(int i, int k);
    logic [3:0] c;
    c = tbl[i][3:0];
    if (c == 4'h0 || (c == 4'h1 && k != 3) || (c == 4'h3 && k == 0)) begin
      return tbl[i][11:4];
    end
    return wv[i];
  endfunction

  // read back every implemented register
  task sweep(input int k);
    for (int i = 0; i < 44; i++) begin
      ldcb_host_inst.pick(tbl[i][23:20], tbl[i][19:12]);
      rd(1'b1, exp_val(i, k));
    end
  endtask

  // load random contents into every implemented register
  task fill;
    for (int i = 0; i < 44; i++) begin
      wv[i] = 8'($random(seed));
      ldcb_host_inst.pick(tbl[i][23:20], tbl[i][19:12]);
      wr(1'b1, wv[i]);
    end
  endtask

  // apply one reset source, then reopen configuration state unless the source was soft
  task hit(input int k);
    case (k)
      0: rst_i <= 1'b1;
      1: bus_reset_pin_n_i <= 1'b0;
      2: main_por_i <= 1'b1;
      default: begin
        wr(1'b0, 8'h02);
        wr(1'b1, 8'h01);
      end
    endcase
    if (k < 3) begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus_reset_pin_n_i <= 1'b1;
      main_por_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check({7'h00, cfg_mode_o}, 8'h00);
      wr(1'b0, 8'h55);
    end else begin
      repeat (3) @(posedge clk_i);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(1'b0, 8'h55);
    sweep(0);
    for (int k = 0; k < 4; k++) begin
      fill();
      pv = 8'($random(seed)) | 8'hA0;
      wr(1'b0, 8'h22);
      wr(1'b1, pv);
      hit(k);
      check(power_ctl_o, (k == 0) ? 8'h00 : 8'hA0);
      wr(1'b0, 8'h22);
      rd(1'b1, (k == 0) ? 8'h00 : 8'hA0);
      wr(1'b0, 8'h07);
      rd(1'b0, 8'h07);
      rd(1'b1, 8'h00);
      sweep(k);
    end
    wr(1'b0, 8'hAA);
    wr(1'b1, 8'h5A);
    rd(1'b1, 8'h00);
    wr(1'b0, 8'h55);
    foreach (rsv[j]) begin
      ldcb_host_inst.pick(rsv[j][11:8], rsv[j][7:0]);
      wr(1'b1, 8'hFF);
      rd(1'b1, 8'h00);
    end
    sweep(3);
    wrap_up();
  end

  // about 4000 cycles are needed; allow a wide margin
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
endmodule
